// [rtl/cap_cfg.svh]
// constants of the comms access port: offsets, field values, responses
`ifndef CAP_CFG_SVH
`define CAP_CFG_SVH

// register word offsets on the access-port bus
`define CAP_OFS_DATA_WORD 8'h00
`define CAP_OFS_DATA_BLOCK 8'h04
`define CAP_OFS_STATUS 8'h08
`define CAP_OFS_CTRL 8'h0c
`define CAP_OFS_EV_STATUS 8'h10
`define CAP_OFS_EV_ENABLE 8'h14
`define CAP_OFS_EV_CLEAR 8'h18
`define CAP_OFS_IDENTITY 8'hfc
`define CAP_OFS_COM_LAST 8'h7c

// bus answers
`define CAP_RESP_OKAY 2'h0
`define CAP_RESP_SLVERR 2'h2

// identity fields
`define CAP_ID_CLASS 4'h1
`define CAP_ID_TYPE 4'h0
`define CAP_ID_RSVD 5'h00

// control and event layout
`define CAP_CTRL_RESET 1'h1
`define CAP_EV_W 3
`define CAP_EV_ABORTED 0
`define CAP_EV_DRAINED 1
`define CAP_EV_RX 2

`endif

// [rtl/cap_pkg.sv]
// types of the comms access port
`include "cap_cfg.svh"

package cap_pkg;

    typedef enum logic [1:0] {CAP_W_IDLE, CAP_W_STALL, CAP_W_RESP} cap_wstate_type;

    typedef struct packed {
        cap_wstate_type wst;
        logic awready;
        logic aw_held;
        logic [7:0] aw_addr;
        logic wready;
        logic w_held;
        logic w_lane0;
        logic [31:0] w_data;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rx_pop;
        logic rx_prev;
        logic abort_en;
    } cap_top_type;

    typedef struct packed {
        logic hold;
        logic pending;
        logic [31:0] data;
    } cap_push_type;

    typedef struct packed {
        logic [`CAP_EV_W-1:0] status;
        logic [`CAP_EV_W-1:0] enable;
        logic irq;
    } cap_irq_type;

endpackage : cap_pkg

// [rtl/cap_push_if.sv]
// link between the register front end and the transmit push stage
`timescale 1ns/1ps
`default_nettype none

interface cap_push_if;
    logic push_valid;
    logic [31:0] push_data;
    logic abandon;
    logic done;
    logic drained;
    logic pending;
    logic space;

    modport ctl (
        output push_valid, push_data, abandon,
        input done, drained, pending, space
    );
    modport eng (
        input push_valid, push_data, abandon,
        output done, drained, pending, space
    );
endinterface : cap_push_if

`default_nettype wire

// [rtl/cap_push.sv]
// holds one outgoing word for the transmit engine and the pending flag
`timescale 1ns/1ps
`default_nettype none

module cap_push (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // front end
    cap_push_if.eng p,
    // transmit engine
    output logic tx_valid,
    output logic [31:0] tx_data,
    input wire logic tx_ready
);

    cap_pkg::cap_push_type r;
    cap_pkg::cap_push_type n;
    logic take;

    assign take = r.hold && tx_ready;
    assign p.done = take && !r.pending;
    assign p.drained = take && r.pending;
    assign p.pending = r.pending;
    assign p.space = !r.hold && !r.pending && tx_ready;
    assign tx_valid = r.hold;
    assign tx_data = r.data;

    always_comb begin
        n = r;
        if (take) begin
            n.hold = 1'b0;
            n.pending = 1'b0;
        end
        // an abort that meets the acceptance edge loses: the word went out
        if (p.abandon && r.hold && !take) begin
            n.pending = 1'b1;
        end
        if (p.push_valid && !r.hold) begin
            n.hold = 1'b1;
            n.data = p.push_data;
        end
        if (!aresetn) begin
            n = '{hold: 1'b0, pending: 1'b0, data: 32'h0000_0000};
        end
    end

    always_ff @(posedge aclk) begin
        r <= n;
    end

endmodule : cap_push

`default_nettype wire

// [rtl/cap_irq.sv]
// sticky event status, enable mask and one level interrupt
`timescale 1ns/1ps
`default_nettype none
`include "cap_cfg.svh"

module cap_irq (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // events, one-cycle pulses
    input wire logic [`CAP_EV_W-1:0] events,
    // software access
    input wire logic en_we,
    input wire logic clr_we,
    input wire logic [`CAP_EV_W-1:0] wr_bits,
    output logic [`CAP_EV_W-1:0] status,
    output logic [`CAP_EV_W-1:0] enable,
    // interrupt
    output logic irq
);

    cap_pkg::cap_irq_type r;
    cap_pkg::cap_irq_type n;

    assign status = r.status;
    assign enable = r.enable;
    assign irq = r.irq;

    always_comb begin
        n = r;
        if (clr_we) begin
            n.status = r.status & ~wr_bits;
        end
        // set after clear so a same-cycle event survives the clear
        n.status = n.status | events;
        if (en_we) begin
            n.enable = wr_bits;
        end
        n.irq = |(n.status & n.enable);
        if (!aresetn) begin
            n = '{status: '0, enable: '0, irq: 1'b0};
        end
    end

    always_ff @(posedge aclk) begin
        r <= n;
    end

endmodule : cap_irq

`default_nettype wire

// [rtl/cap_top.sv]
// comms access port: register window, abort handling, identity
//
// How it works
// - offsets 0x00-0x7c carry the channel registers and 0x80-0xf8 read zero and ignore writes.
// - the read-only identity register sits at offset 0xfc.
// - the identity class field reads 1, marking a comms access port.
// - abort handling is present and can be switched off by the control register.
// - an abort with no bus write in progress is ignored and changes nothing.
// - an abort during a stalled write ends that write on the same clock.
// - an aborted write that did not finish sets the pending flag until its word is taken.
// - a write ended by an abort is answered with an error response.
// - reads of every register work normally at all times, aborted or not.
// - writes to the data word or data block register while pending answer with an error.
// - only data block writes are accepted without transmit space; data word writes then answer with an error.
// - the type field reads zero; variant, revision and designer are parameters.
`timescale 1ns/1ps
`default_nettype none
`include "cap_cfg.svh"

module cap_top #(
    parameter logic [3:0] VARIANT = 4'h0,
    parameter logic [3:0] REVISION = 4'h0,
    // designer code is arbitrary, set per integration
    parameter logic [10:0] DESIGNER = 11'h0aa
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // abort from the debug port
    input wire logic abort_req,
    // transmit engine
    output logic tx_valid,
    output logic [31:0] tx_data,
    input wire logic tx_ready,
    // receive engine
    input wire logic [31:0] rx_data,
    input wire logic rx_valid,
    output logic rx_pop,
    // interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////

    cap_pkg::cap_top_type r;
    cap_pkg::cap_top_type n;
    cap_push_if push ();
    logic [`CAP_EV_W-1:0] ev_status;
    logic [`CAP_EV_W-1:0] ev_enable;
    logic [`CAP_EV_W-1:0] events;
    logic ev_en_we;
    logic ev_clr_we;
    logic [7:0] wsel;
    logic [7:0] rsel;

    // word-aligned offset, low address bits ignored
    function automatic logic [7:0] cap_word(input logic [7:0] a);
        cap_word = {a[7:2], 2'h0};
    endfunction : cap_word

    assign wsel = cap_word(r.aw_addr);
    assign rsel = cap_word(araddr);

    assign awready = r.awready;
    assign wready = r.wready;
    assign bvalid = r.bvalid;
    assign bresp = r.bresp;
    assign arready = r.arready;
    assign rvalid = r.rvalid;
    assign rdata = r.rdata;
    assign rresp = r.rresp;
    assign rx_pop = r.rx_pop;

    ////////////////////////////////////////////////////////////////////////////

    // read data for a word offset; no side effect except the receive pop
    function automatic logic [31:0] cap_read(
        input logic [7:0] sel,
        input logic [31:0] rxd,
        input logic rxv,
        input logic pend,
        input logic txr,
        input logic aen,
        input logic [`CAP_EV_W-1:0] sts,
        input logic [`CAP_EV_W-1:0] ena
    );
        cap_read = 32'h0000_0000;
        case (sel)
            `CAP_OFS_DATA_WORD: begin
                cap_read = rxv ? rxd : 32'h0000_0000;
            end
            `CAP_OFS_STATUS: begin
                cap_read = {29'h0000_0000, rxv, txr, pend};
            end
            `CAP_OFS_CTRL: begin
                cap_read = {31'h0000_0000, aen};
            end
            `CAP_OFS_EV_STATUS: begin
                cap_read = {29'h0000_0000, sts};
            end
            `CAP_OFS_EV_ENABLE: begin
                cap_read = {29'h0000_0000, ena};
            end
            `CAP_OFS_IDENTITY: begin
                cap_read = {REVISION, DESIGNER, `CAP_ID_CLASS, `CAP_ID_RSVD, VARIANT,
                    `CAP_ID_TYPE};
            end
            default: begin
                cap_read = 32'h0000_0000;
            end
        endcase
    endfunction : cap_read

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        n = r;
        n.rx_pop = 1'b0;
        n.rx_prev = rx_valid;
        push.push_valid = 1'b0;
        push.push_data = r.w_data;
        push.abandon = 1'b0;
        ev_en_we = 1'b0;
        ev_clr_we = 1'b0;
        events = '0;
        events[`CAP_EV_RX] = rx_valid && !r.rx_prev;
        events[`CAP_EV_DRAINED] = push.drained;

        // address and data are taken independently, in either order
        if (r.awready && awvalid) begin
            n.awready = 1'b0;
            n.aw_held = 1'b1;
            n.aw_addr = awaddr;
        end
        if (r.wready && wvalid) begin
            n.wready = 1'b0;
            n.w_held = 1'b1;
            n.w_data = wdata;
            n.w_lane0 = wstrb[0];
        end

        case (r.wst)
            cap_pkg::CAP_W_IDLE: begin
                if (r.aw_held && r.w_held) begin
                    n.bresp = `CAP_RESP_OKAY;
                    n.wst = cap_pkg::CAP_W_RESP;
                    n.bvalid = 1'b1;
                    case (wsel)
                        `CAP_OFS_DATA_WORD: begin
                            // refused unless the engine has room now, where a block write would wait for it
                            if (push.pending || !push.space) begin
                                n.bresp = `CAP_RESP_SLVERR;
                            end else begin
                                push.push_valid = 1'b1;
                                n.bvalid = 1'b0;
                                n.wst = cap_pkg::CAP_W_STALL;
                            end
                        end
                        `CAP_OFS_DATA_BLOCK: begin
                            if (push.pending) begin
                                n.bresp = `CAP_RESP_SLVERR;
                            end else begin
                                push.push_valid = 1'b1;
                                n.bvalid = 1'b0;
                                n.wst = cap_pkg::CAP_W_STALL;
                            end
                        end
                        `CAP_OFS_CTRL: begin
                            if (r.w_lane0) begin
                                n.abort_en = r.w_data[0];
                            end
                        end
                        `CAP_OFS_EV_ENABLE: begin
                            ev_en_we = r.w_lane0;
                        end
                        `CAP_OFS_EV_CLEAR: begin
                            ev_clr_we = r.w_lane0;
                        end
                        default: begin
                            // read-only, reserved and unused words drop the write
                            n.bresp = `CAP_RESP_OKAY;
                        end
                    endcase
                end
            end
            cap_pkg::CAP_W_STALL: begin
                // normal completion wins over an abort in the same cycle
                if (push.done) begin
                    n.bvalid = 1'b1;
                    n.bresp = `CAP_RESP_OKAY;
                    n.wst = cap_pkg::CAP_W_RESP;
                end else if (abort_req && r.abort_en) begin
                    push.abandon = 1'b1;
                    events[`CAP_EV_ABORTED] = 1'b1;
                    n.bvalid = 1'b1;
                    n.bresp = `CAP_RESP_SLVERR;
                    n.wst = cap_pkg::CAP_W_RESP;
                end
            end
            cap_pkg::CAP_W_RESP: begin
                if (bready) begin
                    n.bvalid = 1'b0;
                    n.aw_held = 1'b0;
                    n.w_held = 1'b0;
                    n.awready = 1'b1;
                    n.wready = 1'b1;
                    n.wst = cap_pkg::CAP_W_IDLE;
                end
            end
            default: begin
                n.wst = cap_pkg::CAP_W_IDLE;
            end
        endcase
        // outside a stall an abort touches nothing: only the stall state decodes it

        // reads never wait and are unaffected by aborts
        if (r.arready && arvalid) begin
            n.arready = 1'b0;
            n.rvalid = 1'b1;
            n.rresp = `CAP_RESP_OKAY;
            n.rdata = cap_read(rsel, rx_data, rx_valid, push.pending, tx_ready,
                r.abort_en, ev_status, ev_enable);
            n.rx_pop = (rsel == `CAP_OFS_DATA_WORD) && rx_valid;
        end else if (r.rvalid && rready) begin
            n.rvalid = 1'b0;
            n.arready = 1'b1;
        end

        if (!aresetn) begin
            n = '{wst: cap_pkg::CAP_W_IDLE, awready: 1'b1, aw_held: 1'b0, aw_addr: 8'h00,
                wready: 1'b1, w_held: 1'b0, w_lane0: 1'b0, w_data: 32'h0000_0000,
                bvalid: 1'b0, bresp: `CAP_RESP_OKAY, arready: 1'b1, rvalid: 1'b0,
                rdata: 32'h0000_0000, rresp: `CAP_RESP_OKAY, rx_pop: 1'b0,
                rx_prev: 1'b0, abort_en: `CAP_CTRL_RESET};
        end
    end

    always_ff @(posedge aclk) begin
        r <= n;
    end

    ////////////////////////////////////////////////////////////////////////////

    cap_push u_push (
        .aclk(aclk),
        .aresetn(aresetn),
        .p(push.eng),
        .tx_valid(tx_valid),
        .tx_data(tx_data),
        .tx_ready(tx_ready)
    );

    cap_irq u_irq (
        .aclk(aclk),
        .aresetn(aresetn),
        .events(events),
        .en_we(ev_en_we),
        .clr_we(ev_clr_we),
        .wr_bits(r.w_data[`CAP_EV_W-1:0]),
        .status(ev_status),
        .enable(ev_enable),
        .irq(irq)
    );

endmodule : cap_top

`default_nettype wire

// [tb/cap_top_chk.sv]
// pin-level assertions of the comms access port
`timescale 1ns/1ps
`default_nettype none
`include "cap_cfg.svh"

module cap_top_chk #(
    parameter logic [3:0] VARIANT = 4'h0,
    parameter logic [3:0] REVISION = 4'h0,
    parameter logic [10:0] DESIGNER = 11'h0aa
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    // abort and transmit side
    input wire logic abort_req,
    input wire logic tx_valid,
    input wire logic [31:0] tx_data,
    input wire logic tx_ready
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // shadow of the abort enable, rebuilt from finished control writes
    logic [7:0] aw_seen;
    logic w_bit;
    logic abort_on;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_seen <= 8'h00;
            w_bit <= `CAP_CTRL_RESET;
            abort_on <= `CAP_CTRL_RESET;
        end else begin
            if (awvalid && awready) begin
                aw_seen <= awaddr;
            end
            if (wvalid && wready) begin
                w_bit <= wstrb[0] ? wdata[0] : abort_on;
            end
            if (bvalid && bready && {aw_seen[7:2], 2'h0} == `CAP_OFS_CTRL) begin
                abort_on <= w_bit;
            end
        end
    end

    // a data write held inside the block while the engine has no space
    sequence s_stall;
        tx_valid && !tx_ready && !awready && !bvalid;
    endsequence
    sequence s_take;
        tx_valid && tx_ready && !awready && !bvalid;
    endsequence

    a_abort_ends_stall: assert property (s_stall ##0 (abort_req && abort_on) |=>
        bvalid && bresp == `CAP_RESP_SLVERR) else $error("abort left write hanging");
    a_abort_off_ignored: assert property (s_stall ##0 (abort_req && !abort_on) |=>
        !bvalid) else $error("disabled abort ended write");
    a_take_answers: assert property (s_take |-> ##[1:2]
        (bvalid && bresp == `CAP_RESP_OKAY)) else $error("taken word not answered");
    a_idle_abort: assert property (abort_req && awready && !bvalid |=> !bvalid)
        else $error("idle abort answered");
    a_tx_word_holds: assert property (tx_valid && !tx_ready |=>
        tx_valid && $stable(tx_data)) else $error("offered word dropped");
    a_read_next: assert property (arvalid && arready |=>
        rvalid && rresp == `CAP_RESP_OKAY) else $error("read answer late");
    a_read_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data moved");
    a_resp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer moved");
    a_reserved_zero: assert property (arvalid && arready && araddr >= 8'h80 &&
        araddr < 8'hfc |=> rdata == 32'h0) else $error("reserved read not zero");
    a_identity_word: assert property (arvalid && arready &&
        araddr == `CAP_OFS_IDENTITY |=> rdata == {REVISION, DESIGNER, `CAP_ID_CLASS,
        `CAP_ID_RSVD, VARIANT, `CAP_ID_TYPE}) else $error("identity word wrong");
endmodule : cap_top_chk

bind cap_top cap_top_chk #(.VARIANT(VARIANT), .REVISION(REVISION), .DESIGNER(DESIGNER)) chk (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .awready(awready), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .bresp(bresp),
    .rresp(rresp), .araddr(araddr), .rdata(rdata), .abort_req(abort_req),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data)
);

`default_nettype wire

// [tb/cap_engine_model.sv]
// transmit and receive engine stand-in on the far side of the port
`timescale 1ns/1ps
`default_nettype none

module cap_engine_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bench control: transmit queue full
    input wire logic stall,
    // transmit side
    input wire logic tx_valid,
    input wire logic [31:0] tx_data,
    output logic tx_ready,
    output var logic [31:0] taken,
    // receive side
    input wire logic rx_pop,
    output var logic rx_valid,
    output var logic [31:0] rx_data
);
    // space only while not stalled; a stall may last as long as the bench likes
    assign tx_ready = !stall;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_valid <= 1'b0;
            // no word yet, so never a stale one
            rx_data <= 32'h0;
            taken <= 32'h0;
        end else begin
            rx_valid <= 1'b1;
            if (!rx_valid)
                rx_data <= 32'hc0de0000;
            else if (rx_pop)
                rx_data <= rx_data + 32'h1;
            if (tx_valid && tx_ready)
                taken <= tx_data;
        end
    end
endmodule : cap_engine_model

`default_nettype wire

// [tb/comms_access_port_abort_id_test.sv]
// self-checking bench of the comms access port
`timescale 1ns/1ps
`default_nettype none
`include "cap_cfg.svh"

module comms_access_port_abort_id_test;
    logic aclk = 1'b0, aresetn = 1'b0, abort_req = 1'b0, stall = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, tx_data, rx_data, taken, word;
    logic awready, wready, bvalid, arready, rvalid, tx_valid, tx_ready, rx_valid, rx_pop, irq;
    logic [1:0] bresp, rresp, resp;
    int err_total = 0;
    int compares = 0;
    // designer code arbitrary
    localparam logic [31:0] ID_EXP = {4'h5, 11'h155, 4'h1, 5'h00, 4'h3, 4'h0};

    cap_top #(.VARIANT(4'h3), .REVISION(4'h5), .DESIGNER(11'h155)) dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .abort_req(abort_req), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_pop(rx_pop), .irq(irq));
    cap_engine_model eng (.aclk(aclk), .aresetn(aresetn), .stall(stall),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .taken(taken),
        .rx_pop(rx_pop), .rx_valid(rx_valid), .rx_data(rx_data));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // address and data offered together, each dropped once taken
    task automatic wc(input string n, input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] e);
        logic ap;
        logic wp;
        ap = 1'b1;
        wp = 1'b1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (ap || wp) begin
            @(posedge aclk);
            ap = ap && !awready;
            wp = wp && !wready;
            awvalid <= ap;
            wvalid <= wp;
        end
        bready <= 1'b1;
        do @(posedge aclk); while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
        chk(n, {30'h0, e}, {30'h0, resp});
    endtask : wc

    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (!rvalid);
        word = rdata;
        rready <= 1'b0;
        chk(n, e, word);
    endtask : rc

    task automatic pulse;
        abort_req <= 1'b1;
        @(posedge aclk);
        abort_req <= 1'b0;
    endtask : pulse

    task automatic tally_and_finish;
        if (err_total == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #5 aclk = ~aclk;
    end

    initial begin
        repeat (5000) @(posedge aclk);
        err_total++;
        tally_and_finish();
    end

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc("ctrl", `CAP_OFS_CTRL, 32'h1);
        rc("identity", `CAP_OFS_IDENTITY, ID_EXP);
        wc("id write", `CAP_OFS_IDENTITY, 32'h0, `CAP_RESP_OKAY);
        rc("identity kept", `CAP_OFS_IDENTITY, ID_EXP);
        for (logic [8:0] a = 9'h080; a < 9'h0fc; a += 9'h03c) begin
            wc("reserved write", a[7:0], 32'hffffffff, `CAP_RESP_OKAY);
            rc("reserved", a[7:0], 32'h0);
        end
        rc("rx word", `CAP_OFS_DATA_WORD, 32'hc0de0000);
        rc("rx next", `CAP_OFS_DATA_WORD, 32'hc0de0001);
        wc("word write", `CAP_OFS_DATA_WORD, 32'h11, `CAP_RESP_OKAY);
        chk("word sent", 32'h11, taken);
        wc("block write", `CAP_OFS_DATA_BLOCK, 32'h22, `CAP_RESP_OKAY);
        chk("block sent", 32'h22, taken);
        pulse();
        rc("status idle", `CAP_OFS_STATUS, 32'h6);
        rc("events idle", `CAP_OFS_EV_STATUS, 32'h4);
        wc("enable", `CAP_OFS_EV_ENABLE, 32'h1, `CAP_RESP_OKAY);
        // abort a data block write stuck on a full queue
        stall <= 1'b1;
        fork
            wc("aborted", `CAP_OFS_DATA_BLOCK, 32'h33, `CAP_RESP_SLVERR);
            begin
                repeat (6) @(posedge aclk);
                pulse();
            end
        join
        rc("pending", `CAP_OFS_STATUS, 32'h5);
        chk("irq raised", 32'h1, {31'h0, irq});
        rc("ev aborted", `CAP_OFS_EV_STATUS, 32'h5);
        wc("word pending", `CAP_OFS_DATA_WORD, 32'h44, `CAP_RESP_SLVERR);
        wc("block pending", `CAP_OFS_DATA_BLOCK, 32'h55, `CAP_RESP_SLVERR);
        rc("ctrl after", `CAP_OFS_CTRL, 32'h1);
        chk("held word", 32'h22, taken);
        wc("clear", `CAP_OFS_EV_CLEAR, 32'h1, `CAP_RESP_OKAY);
        chk("irq cleared", 32'h0, {31'h0, irq});
        stall <= 1'b0;
        do @(posedge aclk); while (tx_valid);
        chk("drained word", 32'h33, taken);
        rc("pending gone", `CAP_OFS_STATUS, 32'h6);
        rc("ev drained", `CAP_OFS_EV_STATUS, 32'h6);
        chk("irq masked", 32'h0, {31'h0, irq});
        wc("word after", `CAP_OFS_DATA_WORD, 32'h66, `CAP_RESP_OKAY);
        chk("word after sent", 32'h66, taken);
        // abort switched off: a stalled block write must wait for space
        wc("abort off", `CAP_OFS_CTRL, 32'h0, `CAP_RESP_OKAY);
        rc("ctrl off", `CAP_OFS_CTRL, 32'h0);
        stall <= 1'b1;
        fork
            wc("unaborted", `CAP_OFS_DATA_BLOCK, 32'h77, `CAP_RESP_OKAY);
            begin
                repeat (6) @(posedge aclk);
                pulse();
                stall <= 1'b0;
            end
        join
        chk("unaborted sent", 32'h77, taken);
        rc("events kept", `CAP_OFS_EV_STATUS, 32'h6);
        tally_and_finish();
    end
endmodule : comms_access_port_abort_id_test

`default_nettype wire
